// >>> hw/aic_column_sync.sv
// per-column comparator synchroniser, latch bypass and interrupt source select
`timescale 1ns/1ns
module aic_column_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the analog column (asynchronous)
    input wire logic cmp_pin,
    input wire logic col_clk_pin,
    // phase clock edges, already synchronised
    input wire logic phase_clock_2_rise,
    input wire logic phase_clock_2_fall,
    // controls
    input wire logic latch_bypass,
    input wire logic direct_sync,
    input wire logic int_select,
    // results
    output logic cmp_bus_ff,
    output logic int_src_ff
);
    logic cmp_s1_ff;
    logic cmp_s2_ff;
    logic ck_s1_ff;
    logic ck_s2_ff;
    logic ck_d_ff;
    logic col_rise;
    logic sync_edge;
    logic nxt_cmp_bus;

    // two-stage synchronisers for comparator and column clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            ck_s1_ff <= 1'b0;
            ck_s2_ff <= 1'b0;
            ck_d_ff <= 1'b0;
        end else begin
            cmp_s1_ff <= cmp_pin;
            cmp_s2_ff <= cmp_s1_ff;
            ck_s1_ff <= col_clk_pin;
            ck_s2_ff <= ck_s1_ff;
            ck_d_ff <= ck_s2_ff;
        end
    end

    assign col_rise = ck_s2_ff & ~ck_d_ff;
    // sample on phase clock 2 or on the undivided column clock
    assign sync_edge = direct_sync ? col_rise : phase_clock_2_rise;

    // bypass follows the synchronised comparator, otherwise hold between sync edges
    always_comb begin
        nxt_cmp_bus = cmp_bus_ff;
        if (latch_bypass || sync_edge) begin
            nxt_cmp_bus = cmp_s2_ff;
        end
    end

    // comparator bus bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_bus_ff <= 1'b0;
        end else begin
            cmp_bus_ff <= nxt_cmp_bus;
        end
    end

    // interrupt source; in bypass the comparator level passes without any sample edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_src_ff <= 1'b0;
        end else begin
            int_src_ff <= int_select ? phase_clock_2_fall : nxt_cmp_bus;
        end
    end
endmodule

// >>> hw/aic_regs.sv
// analog interface control registers on ahb-lite with comparator bus and stall logic
//
// Function
// - mux1 code 10b routes pin 4
// - mux0 codes pick pins 3, 5, 7
// - bit 7 routes column 1 to bus
// - bit 6 routes column 0 to bus
// - static pin field selects static pins
// - precharge clock source select field
// - bit 0 gates precharge clock
// - status bits show comparator bus state
// - interrupt select: data or phase2 fall
// - nonzero bit count alters array readback
// - conversion column field picks comparator
// - stall enable holds writes until phase1
// - comparators synchronised onto comparator bus
// - latch bypass skips synchronisation
// - bypassed interrupt needs no clock
// - column 1 direct or phase2 sync
// - column 0 direct or phase2 sync
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module aic_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog pins and clocks (asynchronous)
    input wire logic [1:0] cmp_pin,
    input wire logic [1:0] col_clk_pin,
    input wire logic phase_clock_1_pin,
    input wire logic phase_clock_2_pin,
    input wire logic div_a_pin,
    input wire logic div_b_pin,
    input wire logic row0_pin,
    // switched-capacitor block write attempt
    input wire logic sc_write_req,
    // analog control outputs
    output logic [3:0] port_pin_enable_ff,
    output logic [1:0] column_bus_route_ff,
    output logic [1:0] static_pin_select_ff,
    output logic precharge_clock_ff,
    output logic [2:0] array_power_level_ff,
    output logic [2:0] reference_select_ff,
    output logic high_bias_ff,
    output logic reference_on_ff,
    output logic ct_blocks_on_ff,
    output logic sc_blocks_on_ff,
    output logic [1:0] cmp_bus_ff,
    output logic [1:0] column_int_ff,
    output logic [2:0] conversion_bit_count_ff,
    output logic conversion_polarity_ff,
    output logic [1:0] conversion_column_ff,
    output logic conversion_cmp_ff,
    output logic readback_alter_ff,
    output logic cpu_stall_ff
);
    logic [7:0] input_select_ff;
    logic [7:0] mux_config_ff;
    logic [7:0] ref_control_ff;
    logic [7:0] cmp_int_ff;
    logic [7:0] sync_control_ff;
    logic [7:0] cmp_sync_ff;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [1:0] ph1_s_ff;
    logic [1:0] ph2_s_ff;
    logic [4:0] clk_s1_ff;
    logic [4:0] clk_s2_ff;
    logic ph1_d_ff;
    logic ph2_d_ff;
    logic phase_clock_1_rise;
    logic phase_clock_2_rise;
    logic phase_clock_2_fall;
    logic addr_ok;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] nxt_rdata;
    logic [1:0] bus_bits;
    logic [1:0] int_bits;
    logic nxt_prechg;

    // address decode; register index is byte address over four
    assign addr_ok = hsel && hready && htrans == aic_pkg::HTRANS_NONSEQ && hsize == aic_pkg::HSIZE_WORD;
    assign idx = haddr[9:2];
    assign wdat = hwdata[7:0];

    // write address phase capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            wr_idx_ff <= idx;
        end
    end

    // zero-wait answers, always okay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read mux; unmapped addresses read zero, write-only count reads zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (idx)
            aic_pkg::IDX_INPUT_SELECT: nxt_rdata = input_select_ff;
            aic_pkg::IDX_MUX_CONFIG: nxt_rdata = mux_config_ff;
            aic_pkg::IDX_REF_CONTROL: nxt_rdata = ref_control_ff;
            aic_pkg::IDX_CMP_STATUS: nxt_rdata = cmp_int_ff | {2'h0, cmp_bus_ff, 4'h0};
            aic_pkg::IDX_SYNC_CONTROL: nxt_rdata = sync_control_ff & 8'h0F;
            aic_pkg::IDX_CMP_SYNC: nxt_rdata = cmp_sync_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data register, loaded at the address phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= {24'h00_0000, nxt_rdata};
        end
    end

    // register writes; reserved bits masked off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_select_ff <= aic_pkg::RST_INPUT_SELECT;
            mux_config_ff <= aic_pkg::RST_MUX_CONFIG;
            ref_control_ff <= aic_pkg::RST_REF_CONTROL;
            cmp_int_ff <= aic_pkg::RST_CMP_STATUS;
            sync_control_ff <= aic_pkg::RST_SYNC_CONTROL;
            cmp_sync_ff <= aic_pkg::RST_CMP_SYNC;
        end else if (wr_pend_ff) begin
            case (wr_idx_ff)
                aic_pkg::IDX_INPUT_SELECT: input_select_ff <= wdat & aic_pkg::MASK_INPUT_SELECT;
                aic_pkg::IDX_MUX_CONFIG: mux_config_ff <= wdat & aic_pkg::MASK_MUX_CONFIG;
                aic_pkg::IDX_REF_CONTROL: ref_control_ff <= wdat & aic_pkg::MASK_REF_CONTROL;
                aic_pkg::IDX_CMP_STATUS: cmp_int_ff <= wdat & aic_pkg::MASK_CMP_INT;
                aic_pkg::IDX_SYNC_CONTROL: sync_control_ff <= wdat & aic_pkg::MASK_SYNC_CONTROL;
                aic_pkg::IDX_CMP_SYNC: cmp_sync_ff <= wdat & aic_pkg::MASK_CMP_SYNC;
                default: ;
            endcase
        end
    end

    // phase clock and precharge source synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph1_s_ff <= 2'h0;
            ph2_s_ff <= 2'h0;
            ph1_d_ff <= 1'b0;
            ph2_d_ff <= 1'b0;
            clk_s1_ff <= 5'h00;
            clk_s2_ff <= 5'h00;
        end else begin
            ph1_s_ff <= {ph1_s_ff[0], phase_clock_1_pin};
            ph2_s_ff <= {ph2_s_ff[0], phase_clock_2_pin};
            ph1_d_ff <= ph1_s_ff[1];
            ph2_d_ff <= ph2_s_ff[1];
            clk_s1_ff <= {col_clk_pin, row0_pin, div_b_pin, div_a_pin};
            clk_s2_ff <= clk_s1_ff;
        end
    end

    assign phase_clock_1_rise = ph1_s_ff[1] & ~ph1_d_ff;
    assign phase_clock_2_rise = ph2_s_ff[1] & ~ph2_d_ff;
    assign phase_clock_2_fall = ~ph2_s_ff[1] & ph2_d_ff;

    // one comparator column per instance
    for (genvar c = 0; c < 2; c++) begin : g_col
        aic_column_sync u_col (
            .clk(clk),
            .rst_n(rst_n),
            .cmp_pin(cmp_pin[c]),
            .col_clk_pin(col_clk_pin[c]),
            .phase_clock_2_rise(phase_clock_2_rise),
            .phase_clock_2_fall(phase_clock_2_fall),
            .latch_bypass(cmp_sync_ff[aic_pkg::POS_LATCH_BYP + c]),
            .direct_sync(cmp_sync_ff[aic_pkg::POS_DIRECT_SYNC + c]),
            .int_select(cmp_int_ff[c]),
            .cmp_bus_ff(bus_bits[c]),
            .int_src_ff(int_bits[c])
        );
    end

    // precharge clock source select and gate
    always_comb begin
        case (mux_config_ff[aic_pkg::POS_PRECHG_SEL +: 3])
            aic_pkg::PCK_OFF: nxt_prechg = 1'b0;
            aic_pkg::PCK_DIV_A: nxt_prechg = clk_s2_ff[0];
            aic_pkg::PCK_DIV_B: nxt_prechg = clk_s2_ff[1];
            aic_pkg::PCK_ROW0: nxt_prechg = clk_s2_ff[2];
            aic_pkg::PCK_COL0: nxt_prechg = clk_s2_ff[3];
            aic_pkg::PCK_COL1: nxt_prechg = clk_s2_ff[4];
            default: nxt_prechg = 1'b0;
        endcase
        nxt_prechg = nxt_prechg & mux_config_ff[aic_pkg::POS_PRECHG_EN];
    end

    // analog control decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_pin_enable_ff <= 4'h0;
            column_bus_route_ff <= 2'h0;
            static_pin_select_ff <= 2'h0;
            precharge_clock_ff <= 1'b0;
        end else begin
            port_pin_enable_ff[0] <= input_select_ff[1:0] == aic_pkg::MUX0_PIN3;
            port_pin_enable_ff[1] <= input_select_ff[1:0] == aic_pkg::MUX0_PIN5;
            port_pin_enable_ff[2] <= input_select_ff[1:0] == aic_pkg::MUX0_PIN7;
            port_pin_enable_ff[3] <= input_select_ff[aic_pkg::POS_MUX1_IN +: 2] == aic_pkg::MUX1_PIN4;
            column_bus_route_ff[1] <= mux_config_ff[aic_pkg::POS_COL1_ROUTE];
            column_bus_route_ff[0] <= mux_config_ff[aic_pkg::POS_COL0_ROUTE];
            static_pin_select_ff <= mux_config_ff[aic_pkg::POS_STATIC_PIN +: 2];
            precharge_clock_ff <= nxt_prechg;
        end
    end

    // reference and array power decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            array_power_level_ff <= 3'h0;
            reference_select_ff <= 3'h0;
            high_bias_ff <= 1'b0;
            reference_on_ff <= 1'b0;
            ct_blocks_on_ff <= 1'b0;
            sc_blocks_on_ff <= 1'b0;
        end else begin
            array_power_level_ff <= ref_control_ff[aic_pkg::POS_POWER +: 3];
            reference_select_ff <= ref_control_ff[5:3];
            high_bias_ff <= ref_control_ff[6];
            reference_on_ff <= ref_control_ff[1:0] != 2'h0;
            ct_blocks_on_ff <= ref_control_ff[1:0] != 2'h0;
            sc_blocks_on_ff <= ref_control_ff[2] && ref_control_ff[1:0] != 2'h0;
        end
    end

    // comparator bus, interrupt sources and conversion outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_bus_ff <= 2'h0;
            column_int_ff <= 2'h0;
            conversion_bit_count_ff <= 3'h0;
            conversion_polarity_ff <= 1'b0;
            conversion_column_ff <= 2'h0;
            conversion_cmp_ff <= 1'b0;
            readback_alter_ff <= 1'b0;
        end else begin
            cmp_bus_ff <= bus_bits;
            column_int_ff <= int_bits;
            conversion_bit_count_ff <= sync_control_ff[aic_pkg::POS_BIT_COUNT +: 3];
            conversion_polarity_ff <= sync_control_ff[aic_pkg::POS_POLARITY];
            conversion_column_ff <= sync_control_ff[aic_pkg::POS_CONV_COL +: 2];
            case (sync_control_ff[aic_pkg::POS_CONV_COL +: 2])
                aic_pkg::CCOL_0: conversion_cmp_ff <= bus_bits[0];
                aic_pkg::CCOL_1: conversion_cmp_ff <= bus_bits[1];
                default: conversion_cmp_ff <= 1'b0;
            endcase
            readback_alter_ff <= sync_control_ff[aic_pkg::POS_BIT_COUNT +: 3] != 3'h0;
        end
    end

    // write stall: set by a switched-capacitor write, released by phase clock 1 rise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_stall_ff <= 1'b0;
        end else begin
            if (sc_write_req && sync_control_ff[aic_pkg::POS_STALL_EN]) begin
                cpu_stall_ff <= 1'b1;
            end else if (phase_clock_1_rise) begin
                cpu_stall_ff <= 1'b0;
            end
        end
    end

    // stall only when enabled
    stall_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        sc_write_req && !sync_control_ff[aic_pkg::POS_STALL_EN] && !cpu_stall_ff |=> !cpu_stall_ff)
        else $error("stall without enable");
    // stall ends on phase 1 rise
    stall_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_stall_ff && phase_clock_1_rise && !sc_write_req |=> !cpu_stall_ff)
        else $error("stall not released");
    // readback flag follows count
    readback_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 readback_alter_ff == ($past(sync_control_ff[6:4]) != 3'h0))
        else $error("readback flag wrong");
    // pin 4 only for code 10b
    mux1_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 port_pin_enable_ff[3] == ($past(input_select_ff[3:2]) == 2'h2))
        else $error("mux1 pin wrong");
    // pin 3 for code 01b
    mux0_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 port_pin_enable_ff[0] == ($past(input_select_ff[1:0]) == 2'h1))
        else $error("mux0 pin wrong");
    // precharge gated off
    prechg_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !mux_config_ff[0] |=> !precharge_clock_ff)
        else $error("precharge not gated");
    // switched capacitor power
    sc_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        ref_control_ff[2:0] == 3'h4 |=> !sc_blocks_on_ff && !ct_blocks_on_ff)
        else $error("blocks on at code 100b");
    // column route follows bit 7
    col_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 column_bus_route_ff[1] == $past(mux_config_ff[7]))
        else $error("column 1 route wrong");
    // a switched-capacitor write while stalling is enabled
    sequence stall_req_s;
        sc_write_req && sync_control_ff[aic_pkg::POS_STALL_EN];
    endsequence
    // stall raised on an enabled write
    stall_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        stall_req_s |=> cpu_stall_ff)
        else $error("stall not raised");
    // column clock 0 as precharge source
    prechg_col_a: assert property (@(posedge clk) disable iff (!rst_n)
        mux_config_ff[3:0] == 4'h9 |=> precharge_clock_ff == $past(clk_s2_ff[3]))
        else $error("precharge source wrong");
    // conversion comparator follows column 1
    conv_col_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_control_ff[2:1] == 2'h1 |=> conversion_cmp_ff == $past(bus_bits[1]))
        else $error("conversion column wrong");
endmodule

// >>> pkg/aic_pkg.sv
// package: register map, field layout, reset values and codes for the analog interface control block
package aic_pkg;
    // register indices; the byte address on the bus is the index times four
    localparam logic [7:0] IDX_INPUT_SELECT = 8'h60;
    localparam logic [7:0] IDX_MUX_CONFIG = 8'h61;
    localparam logic [7:0] IDX_REF_CONTROL = 8'h63;
    localparam logic [7:0] IDX_CMP_STATUS = 8'h64;
    localparam logic [7:0] IDX_SYNC_CONTROL = 8'h65;
    localparam logic [7:0] IDX_CMP_SYNC = 8'h66;
    // reset values
    localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
    localparam logic [7:0] RST_MUX_CONFIG = 8'h00;
    localparam logic [7:0] RST_REF_CONTROL = 8'h00;
    localparam logic [7:0] RST_CMP_STATUS = 8'h00;
    localparam logic [7:0] RST_SYNC_CONTROL = 8'h00;
    localparam logic [7:0] RST_CMP_SYNC = 8'h00;
    // writable bit masks per register (reserved bits read zero)
    localparam logic [7:0] MASK_INPUT_SELECT = 8'h0F;
    localparam logic [7:0] MASK_MUX_CONFIG = 8'hFF;
    localparam logic [7:0] MASK_REF_CONTROL = 8'h7F;
    localparam logic [7:0] MASK_CMP_INT = 8'h03;
    localparam logic [7:0] MASK_SYNC_CONTROL = 8'h7F;
    localparam logic [7:0] MASK_CMP_SYNC = 8'h33;
    // field positions
    localparam int POS_MUX1_IN = 2;
    localparam int POS_MUX0_IN = 0;
    localparam int POS_COL1_ROUTE = 7;
    localparam int POS_COL0_ROUTE = 6;
    localparam int POS_STATIC_PIN = 4;
    localparam int POS_PRECHG_SEL = 1;
    localparam int POS_PRECHG_EN = 0;
    localparam int POS_POWER = 0;
    localparam int POS_CMP_STATE = 4;
    localparam int POS_BIT_COUNT = 4;
    localparam int POS_POLARITY = 3;
    localparam int POS_CONV_COL = 1;
    localparam int POS_STALL_EN = 0;
    localparam int POS_LATCH_BYP = 4;
    localparam int POS_DIRECT_SYNC = 0;
    // pin select codes
    localparam logic [1:0] MUX1_PIN4 = 2'h2;
    localparam logic [1:0] MUX0_PIN3 = 2'h1;
    localparam logic [1:0] MUX0_PIN5 = 2'h2;
    localparam logic [1:0] MUX0_PIN7 = 2'h3;
    // precharge clock source codes
    localparam logic [2:0] PCK_OFF = 3'h0;
    localparam logic [2:0] PCK_DIV_A = 3'h1;
    localparam logic [2:0] PCK_DIV_B = 3'h2;
    localparam logic [2:0] PCK_ROW0 = 3'h3;
    localparam logic [2:0] PCK_COL0 = 3'h4;
    localparam logic [2:0] PCK_COL1 = 3'h5;
    // conversion column codes
    localparam logic [1:0] CCOL_0 = 2'h0;
    localparam logic [1:0] CCOL_1 = 2'h1;
    // ahb codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// >>> testbench/aic_analog_model.sv
// analog array stand-in: comparators, phase clocks, column and divided clocks
`timescale 1ns/1ns
module aic_analog_model (
    // controls from the bench
    input wire logic [1:0] cmp_level,
    input wire logic phi_hold,
    // pins toward the block
    output logic [1:0] cmp_pin,
    output logic [1:0] col_clk_pin,
    output logic phase_clock_1_pin,
    output logic phase_clock_2_pin,
    output logic div_a_pin,
    output logic div_b_pin,
    output logic row0_pin
);
    // comparator outputs follow the bench's analog levels
    assign cmp_pin = cmp_level;
    // phase 2 is the complement of phase 1
    assign phase_clock_2_pin = ~phase_clock_1_pin;
    // start levels
    initial begin
        col_clk_pin = 2'h0;
        phase_clock_1_pin = 1'h0;
        div_a_pin = 1'h0;
        div_b_pin = 1'h0;
        row0_pin = 1'h0;
    end
    // phase clocks, frozen while the bench holds them
    always #40 begin
        if (!phi_hold) begin
            phase_clock_1_pin = ~phase_clock_1_pin;
        end
    end
    // free running column, divided and row clocks
    always #30 col_clk_pin[0] = ~col_clk_pin[0];
    always #35 col_clk_pin[1] = ~col_clk_pin[1];
    always #50 div_a_pin = ~div_a_pin;
    always #60 div_b_pin = ~div_b_pin;
    always #90 row0_pin = ~row0_pin;
endmodule

// >>> testbench/aic_regs_tb_top.sv
// self-checking bench for the analog interface control registers
`timescale 1ns/1ns
module aic_regs_tb_top;
    logic clk, rst_n, hsel, hwrite, hready, sc_write_req, phi_hold, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, cmp_level, col_clk_pin, cmp_pin, route, spin, cbus, cint, ccol;
    logic [2:0] hsize, array_power_level, rsel, cnt;
    logic [3:0] pin_en;
    logic phase_clock_1_pin, phase_clock_2_pin, div_a_pin, div_b_pin, row0_pin, pck, ron, cton, scon, hbe, pol, ccmp, ralt, stall;
    int n_fail, n_compared;

    // clock and single-slave ready
    initial clk = 1'h0;
    always #5 clk = ~clk;
    assign hready = hreadyout;

    aic_analog_model partner (.cmp_level(cmp_level), .phi_hold(phi_hold), .cmp_pin(cmp_pin),
        .col_clk_pin(col_clk_pin), .phase_clock_1_pin(phase_clock_1_pin), .phase_clock_2_pin(phase_clock_2_pin), .div_a_pin(div_a_pin),
        .div_b_pin(div_b_pin), .row0_pin(row0_pin));

    aic_regs dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmp_pin(cmp_pin), .col_clk_pin(col_clk_pin), .phase_clock_1_pin(phase_clock_1_pin), .phase_clock_2_pin(phase_clock_2_pin),
        .div_a_pin(div_a_pin), .div_b_pin(div_b_pin), .row0_pin(row0_pin), .sc_write_req(sc_write_req),
        .port_pin_enable_ff(pin_en), .column_bus_route_ff(route), .static_pin_select_ff(spin),
        .precharge_clock_ff(pck), .array_power_level_ff(array_power_level), .reference_select_ff(rsel), .high_bias_ff(hbe),
        .reference_on_ff(ron), .ct_blocks_on_ff(cton), .sc_blocks_on_ff(scon), .cmp_bus_ff(cbus),
        .column_int_ff(cint), .conversion_bit_count_ff(cnt), .conversion_polarity_ff(pol),
        .conversion_column_ff(ccol), .conversion_cmp_ff(ccmp), .readback_alter_ff(ralt), .cpu_stall_ff(stall));

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one ahb-lite single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= aic_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= aic_pkg::HSIZE_WORD;
        // waits end on ready; only the watchdog cuts a hang
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
        chk({hready, hresp}, 2'h2);
        hsel <= 1'h0;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
        bus(1'h1, idx, d);
    endtask

    task automatic rreg(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'h0, idx, 32'h0);
        chk(rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // wait for the comparator bus under a bound, then compare it
    task automatic wait_bus(input logic [1:0] e, input int lim);
        int n;
        n = 0;
        while (cbus !== e && n < lim) begin @(posedge clk); n++; end
        #1;
        chk(cbus, e);
    endtask

    task automatic t_reset;
        logic [7:0] ix [6];
        ix = '{aic_pkg::IDX_INPUT_SELECT, aic_pkg::IDX_MUX_CONFIG, aic_pkg::IDX_REF_CONTROL,
               aic_pkg::IDX_CMP_STATUS, aic_pkg::IDX_SYNC_CONTROL, aic_pkg::IDX_CMP_SYNC};
        chk({pin_en, route, spin, pck, cbus, cint, ralt, stall, ron, scon}, 32'h0);
        foreach (ix[i]) rreg(ix[i], 32'h0);
        // unmapped place between the registers
        wreg(8'h62, 32'hFF);
        rreg(8'h62, 32'h0);
    endtask

    task automatic t_input_sel;
        for (int i = 0; i < 16; i++) begin
            wreg(aic_pkg::IDX_INPUT_SELECT, i);
            rreg(aic_pkg::IDX_INPUT_SELECT, i);
            chk(pin_en, {i[3:2] == 2'h2, i[1:0] == 2'h3, i[1:0] == 2'h2, i[1:0] == 2'h1});
        end
    endtask

    task automatic t_mux_cfg;
        logic [1:0] saw;
        for (int i = 0; i < 4; i++) begin
            wreg(aic_pkg::IDX_MUX_CONFIG, {i[1:0], i[1:0], 4'h0});
            rreg(aic_pkg::IDX_MUX_CONFIG, {i[1:0], i[1:0], 4'h0});
            chk({route, spin}, {i[1:0], i[1:0]});
        end
        for (int s = 0; s < 12; s++) begin
            wreg(aic_pkg::IDX_MUX_CONFIG, {4'h0, s[3:1], s[0]});
            saw = 2'h0;
            repeat (60) begin @(posedge clk); #1; saw = saw | {pck === 1'h1, pck === 1'h0}; end
            chk(saw, (s[0] && s[3:1] != 3'h0) ? 2'h3 : 2'h1);
        end
    endtask

    task automatic t_power;
        logic [7:0] v;
        for (int p = 0; p < 8; p++) begin
            v = {1'h0, p[0], 3'h3, p[2:0]};
            wreg(aic_pkg::IDX_REF_CONTROL, v);
            rreg(aic_pkg::IDX_REF_CONTROL, v);
            chk({array_power_level, rsel, hbe, ron, cton, scon}, {p[2:0], 3'h3, p[0], p[1:0] != 2'h0, p[1:0] != 2'h0,
                p[2] && p[1:0] != 2'h0});
        end
    endtask

    task automatic t_comparator;
        logic saw;
        wreg(aic_pkg::IDX_CMP_SYNC, 32'h0);
        phi_hold <= 1'h1;
        cmp_level <= 2'h3;
        tick(30);
        chk(cbus, 2'h0);
        phi_hold <= 1'h0;
        wait_bus(2'h3, 30);
        rreg(aic_pkg::IDX_CMP_STATUS, 32'h30);
        chk(cint, 2'h3);
        phi_hold <= 1'h1;
        wreg(aic_pkg::IDX_CMP_STATUS, 32'h3);
        tick(6);
        chk(cint, 2'h0);
        phi_hold <= 1'h0;
        saw = 1'h0;
        repeat (30) begin @(posedge clk); #1; saw = saw | (cint === 2'h3); end
        chk(saw, 1'h1);
        wreg(aic_pkg::IDX_CMP_STATUS, 32'h0);
        cmp_level <= 2'h1;
        wait_bus(2'h1, 30);
        wreg(aic_pkg::IDX_SYNC_CONTROL, 32'h0);
        tick(3);
        chk(ccmp, 1'h1);
        wreg(aic_pkg::IDX_SYNC_CONTROL, 32'h2);
        tick(3);
        chk(ccmp, 1'h0);
        phi_hold <= 1'h1;
        wreg(aic_pkg::IDX_CMP_SYNC, 32'h30);
        cmp_level <= 2'h2;
        wait_bus(2'h2, 8);
        tick(2);
        chk(cint, 2'h2);
        wreg(aic_pkg::IDX_CMP_SYNC, 32'h3);
        cmp_level <= 2'h1;
        wait_bus(2'h1, 30);
        rreg(aic_pkg::IDX_CMP_SYNC, 32'h3);
        wreg(aic_pkg::IDX_CMP_SYNC, 32'h0);
        cmp_level <= 2'h2;
        tick(30);
        chk(cbus, 2'h1);
        phi_hold <= 1'h0;
        wreg(aic_pkg::IDX_SYNC_CONTROL, 32'h0);
    endtask

    task automatic t_stall;
        int n;
        phi_hold <= 1'h1;
        wreg(aic_pkg::IDX_SYNC_CONTROL, 32'h3B);
        rreg(aic_pkg::IDX_SYNC_CONTROL, 32'h0B);
        chk({cnt, pol, ccol, ralt}, {3'h3, 1'h1, 2'h1, 1'h1});
        @(posedge clk);
        sc_write_req <= 1'h1;
        @(posedge clk);
        sc_write_req <= 1'h0;
        tick(10);
        chk(stall, 1'h1);
        phi_hold <= 1'h0;
        n = 0;
        while (stall !== 1'h0 && n < 20) begin @(posedge clk); n++; end
        #1;
        chk(stall, 1'h0);
        wreg(aic_pkg::IDX_SYNC_CONTROL, 32'h0);
        tick(2);
        chk(ralt, 1'h0);
        @(posedge clk);
        sc_write_req <= 1'h1;
        @(posedge clk);
        sc_write_req <= 1'h0;
        tick(3);
        chk(stall, 1'h0);
    endtask

    // main sequence: inputs set at time zero, reset for three cycles
    initial begin
        {rst_n, hsel, hwrite, sc_write_req, phi_hold} = 5'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, cmp_level, hsize} = 7'h0;
        n_fail = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        t_reset();
        t_input_sel();
        t_mux_cfg();
        t_power();
        t_comparator();
        t_stall();
        give_verdict();
    end

    // watchdog well past the expected run length
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule
